// ===== core/timer_capture_compare_pair.sv
// Overview of operation
// - Register A in compare mode matches, raises irq A
// - Compare value A held until software rewrites
// - Register B in compare mode matches, raises irq B
// - No capture while a register is comparing
// - Capture mode: trigger copies count into A
// - A trigger: opposite edge of A, or B
// - Capture mode: trigger copies count into B
// - B trigger: valid edge of input A
// - B capture ignores the A source select
// - Opposite-phase capture on A raises no irq
// - Then input B edge only raises irq A
// - Zero compare fires on count zero to one
// - Zero timing also after every counter clear
// - Counter increments on each count clock unless stopped or cleared
// - Mode field: stop, free, edge clear, match clear
`default_nettype none

module timer_capture_compare_pair
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [tcc_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [tcc_pkg::DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [tcc_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire logic [tcc_pkg::NUM_UNITS-1:0] timer_input_a,
    input wire logic [tcc_pkg::NUM_UNITS-1:0] timer_input_b,
    output logic [tcc_pkg::NUM_UNITS-1:0] match_irq_a,
    output logic [tcc_pkg::NUM_UNITS-1:0] match_irq_b
);

    localparam int NU = tcc_pkg::NUM_UNITS;
    localparam int CW = tcc_pkg::CC_W;

    // Byte address of a register index
    function automatic logic [tcc_pkg::ADDR_W-1:0] byte_addr(input logic [15:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction

    // Address decode: {hit, unit, kind}
    function automatic logic [3:0] decode(input logic [tcc_pkg::ADDR_W-1:0] a);
        logic [3:0] r;
        r = 4'h0;
        for (int k = 0; k < NU; k++)
        begin
            if (a == byte_addr(tcc_pkg::IDX_COUNT[k]))
                r = {1'b1, 1'(k), tcc_pkg::KIND_COUNT};
            if (a == byte_addr(tcc_pkg::IDX_CCA[k]))
                r = {1'b1, 1'(k), tcc_pkg::KIND_CCA};
            if (a == byte_addr(tcc_pkg::IDX_CCB[k]))
                r = {1'b1, 1'(k), tcc_pkg::KIND_CCB};
            if (a == byte_addr(tcc_pkg::IDX_CTRL[k]))
                r = {1'b1, 1'(k), tcc_pkg::KIND_CTRL};
        end
        decode = r;
    endfunction

    // Byte-lane merge of a write into a 16-bit register
    function automatic logic [CW-1:0] merge(
        input logic [CW-1:0] old,
        input logic [tcc_pkg::DATA_W-1:0] wd,
        input logic [3:0] be
    );
        logic [CW-1:0] r;
        r = old;
        if (be[0])
            r[7:0] = wd[7:0];
        if (be[1])
            r[15:8] = wd[15:8];
        merge = r;
    endfunction

    // Valid edge test for a pin under an edge selection
    function automatic logic edge_hit(
        input logic [1:0] sel,
        input logic rise,
        input logic fall
    );
        logic r;
        r = 1'b0;
        unique case (tcc_pkg::edge_sel_t'(sel))
            tcc_pkg::EDGE_FALL: r = fall;
            tcc_pkg::EDGE_RISE: r = rise;
            tcc_pkg::EDGE_NONE: r = 1'b0;
            tcc_pkg::EDGE_BOTH: r = rise | fall;
        endcase
        edge_hit = r;
    endfunction

    // Per-unit register views for readback
    logic [CW-1:0] count_r [NU];
    logic [CW-1:0] cca_r [NU];
    logic [CW-1:0] ccb_r [NU];
    logic [CW-1:0] ctrl_r [NU];

    // Bus slave state
    tcc_pkg::bus_state_t state; // Idle or answering
    tcc_pkg::bus_state_t next_state;
    logic [tcc_pkg::DATA_W-1:0] next_readdata;
    logic [3:0] sel; // Decoded access target
    logic sel_hit; // Address is mapped
    logic sel_unit; // Unit addressed
    logic [1:0] sel_kind; // Register addressed
    logic wr_fire; // Write takes effect this edge

    assign sel = decode(address);
    assign sel_hit = sel[3];
    assign sel_unit = sel[2];
    assign sel_kind = sel[1:0];

    // One wait cycle, then the answer
    assign waitrequest = (read | write) & (state != tcc_pkg::BUS_ACK);
    assign wr_fire = write & (state == tcc_pkg::BUS_ACK);

    // Bus next state and read data
    always_comb
    begin
        next_state = state;
        next_readdata = readdata;
        unique case (state)
            tcc_pkg::BUS_IDLE:
            begin
                // Request seen: load read data, answer next cycle
                if (read | write)
                    next_state = tcc_pkg::BUS_ACK;
                if (read)
                begin
                    next_readdata = tcc_pkg::READ_RESET;
                    if (sel_hit)
                    begin
                        unique case (tcc_pkg::reg_kind_t'(sel_kind))
                            tcc_pkg::KIND_COUNT: next_readdata[CW-1:0] = count_r[sel_unit];
                            tcc_pkg::KIND_CCA: next_readdata[CW-1:0] = cca_r[sel_unit];
                            tcc_pkg::KIND_CCB: next_readdata[CW-1:0] = ccb_r[sel_unit];
                            tcc_pkg::KIND_CTRL: next_readdata[CW-1:0] = ctrl_r[sel_unit];
                        endcase
                    end
                end
            end
            tcc_pkg::BUS_ACK:
            begin
                // Answer given; master releases after this edge
                next_state = tcc_pkg::BUS_IDLE;
            end
            default:
            begin
                next_state = tcc_pkg::BUS_IDLE;
            end
        endcase
    end

    // Bus registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= tcc_pkg::BUS_IDLE;
            readdata <= tcc_pkg::READ_RESET;
        end
        else
        begin
            state <= next_state;
            readdata <= next_readdata;
        end
    end

    // One timer unit per iteration
    genvar u;
    generate
        for (u = 0; u < NU; u++)
        begin : g_unit
            logic [CW-1:0] count; // Timer count
            logic [CW-1:0] cca; // Capture/compare A
            logic [CW-1:0] ccb; // Capture/compare B
            logic [CW-1:0] ctrl; // Unit control bits
            logic stepped; // Count reached by an increment
            logic irq_a; // Match pulse A
            logic irq_b; // Match pulse B
            logic [CW-1:0] next_count;
            logic [CW-1:0] next_cca;
            logic [CW-1:0] next_ccb;
            logic [CW-1:0] next_ctrl;
            logic next_stepped;
            logic next_irq_a;
            logic next_irq_b;
            logic a_rise; // Synchronised input A edges
            logic a_fall;
            logic b_rise; // Synchronised input B edges
            logic b_fall;
            logic running; // Mode other than stop
            logic src_opp; // Capture A on opposite edge of A
            logic cap_a; // Register A in capture mode
            logic cap_b; // Register B in capture mode
            logic a_valid; // Valid edge on input A
            logic a_opp; // Opposite-phase edge on input A
            logic b_valid; // Valid edge on input B
            logic hit_a; // Compare A matches
            logic hit_b; // Compare B matches
            logic trig_a; // Capture into A
            logic trig_b; // Capture into B
            logic clear; // Counter clear in running mode
            logic wr_unit; // Write aimed at this unit
            tcc_pkg::op_mode_t op;

            // Edge detection of pins on the count clock
            input_edge_sync sync_a
            (
                .clk(clk),
                .resetn(resetn),
                .pin(timer_input_a[u]),
                .rise(a_rise),
                .fall(a_fall)
            );

            input_edge_sync sync_b
            (
                .clk(clk),
                .resetn(resetn),
                .pin(timer_input_b[u]),
                .rise(b_rise),
                .fall(b_fall)
            );

            // Control field views
            assign op = tcc_pkg::op_mode_t'(ctrl[tcc_pkg::CTRL_OP_LSB +: 2]);
            assign src_opp = ctrl[tcc_pkg::CTRL_SRC_BIT];
            assign cap_a = ctrl[tcc_pkg::CTRL_CAPA_BIT];
            assign cap_b = ctrl[tcc_pkg::CTRL_CAPB_BIT];
            assign running = (op != tcc_pkg::OP_STOP);
            assign wr_unit = wr_fire & sel_hit & (sel_unit == 1'(u));

            // Trigger edges under the edge selections
            assign a_valid = edge_hit(ctrl[tcc_pkg::CTRL_ESA_LSB +: 2], a_rise, a_fall);
            assign a_opp = edge_hit(ctrl[tcc_pkg::CTRL_ESA_LSB +: 2], a_fall, a_rise);
            assign b_valid = edge_hit(ctrl[tcc_pkg::CTRL_ESB_LSB +: 2], b_rise, b_fall);

            // Compare: zero value fires on the step to one
            assign hit_a = running & stepped & ~cap_a &
                ((cca == tcc_pkg::ZERO_CMP) ? (count == tcc_pkg::ZERO_HIT)
                                             : (count == cca));
            assign hit_b = running & stepped & ~cap_b &
                ((ccb == tcc_pkg::ZERO_CMP) ? (count == tcc_pkg::ZERO_HIT)
                                             : (count == ccb));

            // Capture triggers, only in capture mode
            assign trig_a = running & cap_a & (src_opp ? a_opp : b_valid);
            assign trig_b = running & cap_b & a_valid;

            // Clear on input A edge or on match with A
            assign clear = ((op == tcc_pkg::OP_CLR_EDGE) & a_valid) |
                           ((op == tcc_pkg::OP_CLR_MATCH) & hit_a);

            // Counter next value
            always_comb
            begin
                next_count = count;
                next_stepped = 1'b0;
                if (!running)
                begin
                    // Stopped: held at zero
                    next_count = tcc_pkg::COUNT_RESET;
                end
                else if (clear)
                begin
                    // Cleared: next value is not a step
                    next_count = tcc_pkg::COUNT_RESET;
                end
                else
                begin
                    // Counting; overflow wraps to zero
                    next_count = count + tcc_pkg::COUNT_STEP;
                    next_stepped = 1'b1;
                end
            end

            // Capture/compare and control next values
            always_comb
            begin
                next_cca = cca;
                next_ccb = ccb;
                next_ctrl = ctrl;
                // Software writes; compare value held otherwise
                if (wr_unit && (sel_kind == tcc_pkg::KIND_CCA))
                    next_cca = merge(cca, writedata, byteenable);
                if (wr_unit && (sel_kind == tcc_pkg::KIND_CCB))
                    next_ccb = merge(ccb, writedata, byteenable);
                if (wr_unit && (sel_kind == tcc_pkg::KIND_CTRL))
                    next_ctrl = merge(ctrl, writedata, byteenable) & tcc_pkg::CTRL_MASK;
                // Capture of the detection-cycle count wins over a write
                if (trig_a)
                    next_cca = count;
                if (trig_b)
                    next_ccb = count;
            end

            // Interrupt pulses
            always_comb
            begin
                next_irq_a = hit_a;
                next_irq_b = hit_b | trig_b;
                if (running && cap_a)
                begin
                    if (src_opp)
                        next_irq_a = b_valid;
                    else
                        next_irq_a = trig_a;
                end
            end

            // Unit registers
            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    count <= tcc_pkg::COUNT_RESET;
                    cca <= tcc_pkg::CC_RESET;
                    ccb <= tcc_pkg::CC_RESET;
                    ctrl <= tcc_pkg::CTRL_RESET;
                    stepped <= 1'b0;
                    irq_a <= 1'b0;
                    irq_b <= 1'b0;
                end
                else
                begin
                    count <= next_count;
                    cca <= next_cca;
                    ccb <= next_ccb;
                    ctrl <= next_ctrl;
                    stepped <= next_stepped;
                    irq_a <= next_irq_a;
                    irq_b <= next_irq_b;
                end
            end

            // Readback views and outputs
            assign count_r[u] = count;
            assign cca_r[u] = cca;
            assign ccb_r[u] = ccb;
            assign ctrl_r[u] = ctrl;
            assign match_irq_a[u] = irq_a;
            assign match_irq_b[u] = irq_b;
        end
    endgenerate

endmodule

`default_nettype wire

// ===== include/tcc_pkg.sv
`default_nettype none

package tcc_pkg;

    // Number of timer units served by one block
    localparam int NUM_UNITS = 2;
    // Avalon byte address width and data width
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    // Width of counter and capture/compare registers
    localparam int CC_W = 16;

    // Register indices; the byte address is four times the index
    localparam logic [15:0] IDX_COUNT [NUM_UNITS] = '{16'hFF10, 16'hFFB0};
    localparam logic [15:0] IDX_CCA [NUM_UNITS] = '{16'hFF12, 16'hFFB2};
    localparam logic [15:0] IDX_CCB [NUM_UNITS] = '{16'hFF14, 16'hFFB4};
    localparam logic [15:0] IDX_CTRL [NUM_UNITS] = '{16'hFF18, 16'hFFB8};

    // Values after reset
    localparam logic [CC_W-1:0] CC_RESET = 16'h0000;
    localparam logic [CC_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [CC_W-1:0] CTRL_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] READ_RESET = 32'h00000000;

    // Control register field positions
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_SRC_BIT = 2;
    localparam int CTRL_CAPA_BIT = 3;
    localparam int CTRL_CAPB_BIT = 4;
    localparam int CTRL_ESA_LSB = 5;
    localparam int CTRL_ESB_LSB = 7;
    // Writable control bits; the rest read as zero
    localparam logic [CC_W-1:0] CTRL_MASK = 16'h01FF;

    // Compare value zero and the count at which it fires
    localparam logic [CC_W-1:0] ZERO_CMP = 16'h0000;
    localparam logic [CC_W-1:0] ZERO_HIT = 16'h0001;
    // Counter step
    localparam logic [CC_W-1:0] COUNT_STEP = 16'h0001;

    // Register kinds inside one unit
    typedef enum logic [1:0] {
        KIND_COUNT = 2'h0,
        KIND_CCA = 2'h1,
        KIND_CCB = 2'h2,
        KIND_CTRL = 2'h3
    } reg_kind_t;

    // Operating mode of the counter
    typedef enum logic [1:0] {
        OP_STOP = 2'h0,
        OP_FREE = 2'h1,
        OP_CLR_EDGE = 2'h2,
        OP_CLR_MATCH = 2'h3
    } op_mode_t;

    // Valid edge selection of an input pin
    typedef enum logic [1:0] {
        EDGE_FALL = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_NONE = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_sel_t;

    // Bus slave states, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h1,
        BUS_ACK = 2'h2
    } bus_state_t;

endpackage

`default_nettype wire

// ===== core/input_edge_sync.sv
`default_nettype none

module input_edge_sync
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic pin,
    output logic rise,
    output logic fall
);

    logic sync1; // First stage, read only by sync2
    logic sync2; // Second stage, safe level
    logic prev; // Delayed safe level for edges
    logic next_sync1;
    logic next_sync2;
    logic next_prev;

    // Next values of the synchroniser chain
    always_comb
    begin
        next_sync1 = pin;
        next_sync2 = sync1;
        next_prev = sync2;
    end

    // Chain registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev <= 1'b0;
        end
        else
        begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            prev <= next_prev;
        end
    end

    // One-cycle edge pulses from the safe stages
    assign rise = sync2 & ~prev;
    assign fall = ~sync2 & prev;

endmodule

`default_nettype wire

// ===== bench/pulse_source.sv
`default_nettype none

// Pulse sources on the timer input pins; pins move only at a clock edge
module pulse_source
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic [1:0] want_a,
    input wire logic [1:0] want_b,
    output logic [1:0] pin_a,
    output logic [1:0] pin_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] dly1; // First delay stage
    logic [3:0] dly2; // Second delay stage

    // Slow sources lag their requests by two more cycles
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dly1 <= 4'h0;
            dly2 <= 4'h0;
            pin_a <= 2'h0;
            pin_b <= 2'h0;
        end
        else
        begin
            dly1 <= {want_b, want_a};
            dly2 <= dly1;
            pin_a <= slow ? dly2[1:0] : want_a;
            pin_b <= slow ? dly2[3:2] : want_b;
        end
    end
endmodule

`default_nettype wire

// ===== bench/tcc_checker.sv
`default_nettype none

// Port checks of the bus handshake and the interrupt lines
module tcc_checker
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [17:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic [1:0] match_irq_a,
    input wire logic [1:0] match_irq_b
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Exactly one wait cycle per request
    read_wait_a: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
        else $error("read not answered after one wait cycle");
    write_wait_a: assert property ($rose(write) |-> waitrequest ##1 !waitrequest)
        else $error("write not answered after one wait cycle");
    idle_nowait_a: assert property (!read && !write |-> !waitrequest)
        else $error("waitrequest high with no request");
    answer_once_a: assert property (read && !waitrequest |=> !(read && !waitrequest))
        else $error("read answered twice");
    // Read data shape and stability
    upper_zero_a: assert property (read && !waitrequest |-> readdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    hold_data_a: assert property (!read |=> $stable(readdata))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (read && !waitrequest && address[17:2] == 16'h0000
        |-> readdata == 32'h00000000)
        else $error("unmapped read not zero");
    // Stopped after reset, so no interrupt at once
    quiet_start_a: assert property ($rose(resetn) |->
        (match_irq_a == 2'h0 && match_irq_b == 2'h0) [*3])
        else $error("interrupt right after reset");
endmodule

`default_nettype wire

// ===== bench/testbench.sv
`default_nettype none

// Self-checking bench of the capture/compare pair
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0; // Count clock
    logic resetn = 1'b0; // Reset, active low
    logic [17:0] address = 18'h00000;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [31:0] readdata;
    logic waitrequest;
    logic [1:0] pin_a;
    logic [1:0] pin_b;
    logic [1:0] irq_a;
    logic [1:0] irq_b;
    logic [1:0] want_a = 2'h0; // Requested pin levels
    logic [1:0] want_b = 2'h0;
    logic slow = 1'b0; // Partner lags its pins
    logic [31:0] rdv; // Last read data
    logic [31:0] rv; // Random draw
    int err_count = 0;
    int samples_checked = 0;
    int seed;
    int hit1 [2]; // First pulse step, a then b
    int hit2 [2]; // Second pulse step

    always #2 clk = ~clk;

    timer_capture_compare_pair u_dut
    (
        .clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'h3), .readdata(readdata),
        .waitrequest(waitrequest), .timer_input_a(pin_a), .timer_input_b(pin_b),
        .match_irq_a(irq_a), .match_irq_b(irq_b)
    );
    pulse_source u_src
    (
        .clk(clk), .resetn(resetn), .slow(slow), .want_a(want_a), .want_b(want_b),
        .pin_a(pin_a), .pin_b(pin_b)
    );

    // Counts and verdict, then stop
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Exact compare
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Window compare
    task automatic rng(input string what, input int lo, input int hi, input logic [31:0] got);
        samples_checked++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            err_count++;
            $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    // Register index of unit u: 0 count, 1 a, 2 b, 3 control
    function automatic logic [15:0] ix(input int u, input int k);
        return k == 0 ? tcc_pkg::IDX_COUNT[u] : k == 1 ? tcc_pkg::IDX_CCA[u] :
            k == 2 ? tcc_pkg::IDX_CCB[u] : tcc_pkg::IDX_CTRL[u];
    endfunction

    // Compare step of a compare value; zero fires on the step to one
    function automatic int exp_step(input int n);
        return (n == 0) ? 2 : n + 1;
    endfunction

    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        address <= {idx, 2'b00};
        writedata <= {16'h0000, wd};
        read <= ~wr;
        write <= wr;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 20);
        rdv = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (waitrequest !== 1'b0)
        begin
            err_count++;
            $display("BAD bus answer expected 0 seen %b", waitrequest);
            wrap_up();
        end
    endtask

    task automatic w(input logic [15:0] idx, input logic [15:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic r(input logic [15:0] idx, input logic [31:0] exp, input string what);
        bus(1'b0, idx, 16'h0000);
        chk(what, exp, rdv);
    endtask

    // Record pulse steps, toggling pins at steps pa and pb
    task automatic watch(input int u, input int steps, input int pa, input int pb);
        hit1 = '{-1, -1};
        hit2 = '{-1, -1};
        for (int k = 1; k <= steps; k++)
        begin
            @(posedge clk);
            if (k == pa)
                want_a[u] <= ~want_a[u];
            if (k == pb)
                want_b[u] <= ~want_b[u];
            #1;
            for (int c = 0; c < 2; c++)
                if ((c == 0 ? irq_a[u] : irq_b[u]) === 1'b1)
                begin
                    if (hit1[c] < 0)
                        hit1[c] = k;
                    else if (hit2[c] < 0)
                        hit2[c] = k;
                end
        end
    endtask

    // Free-running compare of a and b, pins wiggling meanwhile
    task automatic cmp_run(input int u, input logic [15:0] n, input logic [15:0] m);
        w(ix(u, 1), n);
        w(ix(u, 2), m);
        w(ix(u, 3), 16'h0001);
        watch(u, 50, 10, 12);
        chk("irq a step", exp_step(n), hit1[0]);
        chk("irq a repeat", -1, hit2[0]);
        chk("irq b step", exp_step(m), hit1[1]);
        bus(1'b0, ix(u, 0), 16'h0000);
        rng("count", 50, 56, rdv);
        w(ix(u, 3), 16'h0000);
        r(ix(u, 1), {16'h0000, n}, "held a");
        r(ix(u, 2), {16'h0000, m}, "held b");
    endtask

    // Capture run: set pin levels, start, toggle pins, read the register
    task automatic cap_run(input int u, input logic [15:0] ctl, input logic la, input logic lb,
        input int pa, input int pb, input int k, input int ch, input int ib);
        @(posedge clk);
        want_a[u] <= la;
        want_b[u] <= lb;
        w(ix(u, 1), 16'hFFFF);
        w(ix(u, 2), 16'hFFFF);
        w(ix(u, 3), ctl);
        watch(u, 40, pa, pb);
        w(ix(u, 3), 16'h0000);
        bus(1'b0, ix(u, k), 16'h0000);
        rng("captured", (pa > 0 ? pa : pb) + 1, (pa > 0 ? pa : pb) + 9, rdv);
        rng("capture irq", ib + 1, ib + 9, hit1[ch]);
        chk("irq repeat", -1, hit2[ch]);
        chk("irq other", -1, hit1[1 - ch]);
    endtask

    initial
    begin
        seed = 32'hA262B360;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        w(16'h0000, 16'h1234);
        r(16'h0000, 32'h00000000, "unmapped");
        for (int u = 0; u < 2; u++)
        begin
            for (int k = 0; k < 4; k++)
                r(ix(u, k), 32'h00000000, "reset value");
            w(ix(u, 0), 16'h00FF);
            r(ix(u, 0), 32'h00000000, "count write");
            repeat (3)
            begin
                rv = $random(seed);
                w(ix(u, 1), rv[15:0]);
                w(ix(u, 2), rv[31:16]);
                r(ix(u, 1), {16'h0000, rv[15:0]}, "rw a");
                r(ix(u, 2), {16'h0000, rv[31:16]}, "rw b");
            end
            cmp_run(u, 16'h0000, 16'h002D);
            cmp_run(u, 16'h0020, 16'h0010);
            rv = $random(seed);
            cmp_run(u, {11'h000, rv[4:0]} + 16'h0001, {11'h000, rv[20:16]});
            w(ix(u, 1), {12'h000, rv[11:8]} + 16'h0001);
            w(ix(u, 2), 16'hFFFF);
            w(ix(u, 3), 16'h0003);
            watch(u, 60, 0, 0);
            chk("match clear first", rv[11:8] + 2, hit1[0]);
            chk("match clear period", 2 * (rv[11:8] + 2), hit2[0]);
            w(ix(u, 3), 16'h0000);
            @(posedge clk);
            slow <= (u == 1);
            cap_run(u, 16'h0131, 1'b0, 1'b0, 5, 0, 2, 1, 5);
            cap_run(u, 16'h0135, 1'b0, 1'b0, 5, 0, 2, 1, 5);
            cap_run(u, 16'h0171, 1'b1, 1'b0, 5, 0, 2, 1, 5);
            cap_run(u, 16'h00C9, 1'b0, 1'b0, 0, 5, 1, 0, 5);
            cap_run(u, 16'h00AD, 1'b1, 1'b0, 5, 25, 1, 0, 25);
            @(posedge clk);
            want_a[u] <= 1'b0;
            w(ix(u, 3), 16'h0022);
            watch(u, 40, 5, 0);
            bus(1'b0, ix(u, 0), 16'h0000);
            rng("edge clear count", 26, 38, rdv);
            w(ix(u, 3), 16'h0000);
        end
        wrap_up();
    end
endmodule

bind timer_capture_compare_pair tcc_checker u_chk
(
    .clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
    .readdata(readdata), .waitrequest(waitrequest), .match_irq_a(match_irq_a),
    .match_irq_b(match_irq_b)
);

`default_nettype wire
